/* verilog/acq_pipeline_consts.vh */
// Constants for the acquisition min/max pipeline: register map,
// mode register fields, reset values and timing figures.
// Assumes a 32-bit AXI4-Lite register bus and a 125 MHz system clock.
`ifndef ACQ_PIPELINE_CONSTS_VH
`define ACQ_PIPELINE_CONSTS_VH

// Register byte offsets
`define ACQ_MODE_OFFSET 4'h0
`define ACQ_PERIOD_OFFSET 4'h4
`define ACQ_STATUS_OFFSET 4'h8
`define ACQ_WORD_OFFSET 4'hc

// Mode register fields
`define MODE_EXTREME_BIT 0
`define MODE_DUAL_AXIS_N_BIT 1
`define MODE_REORDER_EN_BIT 2
`define MODE_DIAG_N_BIT 3
`define MODE_TICK_FAST_BIT 4
`define MODE_WIDTH 5

// Reset values: sampling mode, dual axis off, diagnostics off, 20 MHz tick
`define MODE_RESET 5'h1a
`define PERIOD_RESET 16'h0004
`define PERIOD_MIN 16'h0002

// Digitizer code limits
`define CODE_TOP 8'hff
`define CODE_BOTTOM 8'h00

// Timing figures
`define DIGITIZER_RATE_MHZ 20
`define SYS_CLK_MHZ 125
`define FAST_TICK_NS 50
`define SLOW_TICK_NS 100

// AXI responses
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10

`endif

/* verilog/acquisition_min_max_pipeline.v */
// Acquisition pipeline: input buffer, low/high capture registers with
// strobe selector and min/max comparators, reorder buffers, memory buses.
// Assumes digitizer clock and data arrive asynchronously on pins and a
// 32-bit AXI4-Lite master sets the mode and the store period.
//
// Summary of operation
// - Digitizer code is all ones at range top, all zeros at bottom.
// - Digitizer converts continuously at its clock rate regardless of store period.
// - Bytes flow input buffer, capture registers, reorder buffers, then memory.
// - Input buffer takes a byte each sample tick rise and drives comparator bus.
// - Diagnostic select low swaps input buffer for a diagnostic pattern source.
// - Sampling mode strobes capture registers with second phase clock and complement.
// - Dual-axis mode: first phase strobes low, second phase strobes high register.
// - Min/max: the sample at count 3 of each store period (period 4 or more) loads both registers.
// - After initialization lower/higher found become the low/high strobes.
// - Lower found when byte below low; higher found when above high.
// - Comparator strobes pass only after sample tick falls, half tick later.
// - Min/max comparisons run on every sample tick of the store period but the init tick.
// - Capture write asserts one sample tick before each store period ends.
// - Reorder enabled: swap or plain enable half tick before period end.
// - Handoff clock moves both bytes to memory buses, 16 bits parallel.
// - Selector: 11 init, 01 min/max, 10 sampling, 00 dual axis.
// - Selector follows extreme mode, dual-axis bit and init flop state.
// - Min/max emits a one tick init pulse at count 3 of each store period (period 4 or more).
// - Outside min/max the init flops hold control input 0 high; dual-axis mode forces it low.
// - Entry: clear on tick rise, load on first phase, raise on next tick.
// - Selector outputs pass only on a sample tick edge: fall for init and min/max, rise for sampling and dual axis.
// - New initialization starts at each first phase clock rise.
// - Reorder enable low drives only the non-swapping buffers.
// - Phase delay chain steps once per sample tick period.
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "acq_pipeline_consts.vh"

module acquisition_min_max_pipeline
#(
  parameter DATA_W = 8
)
(
  input wire sys_clk_i,
  input wire rst_b_i,
  // Digitizer pins
  input wire digitizer_clock_i,
  input wire [DATA_W-1:0] digitizer_data_i,
  // Acquisition memory side
  output reg [DATA_W-1:0] mem_bus_a_o,
  output reg [DATA_W-1:0] mem_bus_b_o,
  output reg capture_write_o,
  output reg handoff_clock_o,
  output reg swap_drive_o,
  output reg plain_drive_o,
  // AXI4-Lite slave
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  reg [`MODE_WIDTH-1:0] mode;
  reg [15:0] period;
  reg aw_held;
  reg w_held;
  reg [3:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg clk_s1;
  reg clk_s2;
  reg clk_prev;
  reg [DATA_W-1:0] data_s1;
  reg [DATA_W-1:0] data_s2;
  reg [DATA_W-1:0] code;
  reg tick_hi;
  reg tick_prev;
  reg [15:0] cnt;
  reg [3:0] chain;
  reg [DATA_W-1:0] in_buf;
  reg [DATA_W-1:0] diag_pat;
  reg [DATA_W-1:0] low_reg;
  reg [DATA_W-1:0] high_reg;
  reg init_a;
  reg ctrl0;
  reg last_min;
  reg [DATA_W-1:0] reo_low;
  reg [DATA_W-1:0] reo_high;

  wire extreme = mode[`MODE_EXTREME_BIT];
  wire dual_axis_n = mode[`MODE_DUAL_AXIS_N_BIT];
  wire reorder_enable = mode[`MODE_REORDER_EN_BIT];
  wire diag_n = mode[`MODE_DIAG_N_BIT];
  wire tick_fast = mode[`MODE_TICK_FAST_BIT];

  // AXI handshakes: address and data taken in either order, one at a time
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_go = aw_held && w_held;
  wire [31:0] strb_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [31:0] mode_merged = ({27'h0, mode} & ~strb_mask) | (w_data & strb_mask);
  wire [31:0] period_merged = ({16'h0, period} & ~strb_mask) | (w_data & strb_mask);

  // Write channel and register storage
  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_OKAY;
      mode <= `MODE_RESET;
      period <= `PERIOD_RESET;
    end
    else
    begin
      if (aw_take)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `AXI_OKAY;
        if ({aw_addr[3:2], 2'b00} == `ACQ_MODE_OFFSET)
          mode <= mode_merged[`MODE_WIDTH-1:0];
        else if ({aw_addr[3:2], 2'b00} == `ACQ_PERIOD_OFFSET)
          period <= (period_merged[15:0] < `PERIOD_MIN) ? `PERIOD_MIN : period_merged[15:0];
        else
          s_axi_bresp <= `AXI_SLVERR; // Status and word registers are read-only
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel
  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `AXI_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `AXI_OKAY;
      case ({s_axi_araddr[3:2], 2'b00})
        `ACQ_MODE_OFFSET: s_axi_rdata <= {27'h0, mode};
        `ACQ_PERIOD_OFFSET: s_axi_rdata <= {16'h0, period};
        `ACQ_STATUS_OFFSET: s_axi_rdata <= {6'h0, last_min, ctrl0, in_buf, high_reg, low_reg};
        `ACQ_WORD_OFFSET: s_axi_rdata <= {16'h0, mem_bus_b_o, mem_bus_a_o};
        default: s_axi_rdata <= 32'h0;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Pin synchronisers and continuous conversion on every digitizer clock rise
  wire dig_rise = clk_s2 && !clk_prev;
  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_prev <= 1'b0;
      data_s1 <= `CODE_BOTTOM;
      data_s2 <= `CODE_BOTTOM;
      code <= `CODE_BOTTOM;
    end
    else
    begin
      clk_s1 <= digitizer_clock_i;
      clk_s2 <= clk_s1;
      clk_prev <= clk_s2;
      data_s1 <= digitizer_data_i;
      data_s2 <= data_s1;
      if (dig_rise)
        code <= data_s2;
    end
  end

  // Sample tick: digitizer clock itself or divided by two
  wire next_tick_hi = tick_fast ? clk_s2 : (dig_rise ? !tick_hi : tick_hi);
  wire tick_rise = tick_hi && !tick_prev;
  wire tick_fall = !tick_hi && tick_prev;
  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      tick_hi <= 1'b0;
      tick_prev <= 1'b0;
    end
    else
    begin
      tick_hi <= next_tick_hi;
      tick_prev <= tick_hi;
    end
  end

  // Store period timebase and phase delay chain
  wire [15:0] last_cnt = period - 16'h0001;
  wire store_level = (cnt < {1'b0, period[15:1]});
  wire at_end = (cnt >= last_cnt);
  wire fp_rise = chain[0] && !chain[1];
  wire sp_rise = chain[1] && !chain[2];
  wire sp_fall = !chain[1] && chain[2];
  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt <= 16'h0;
      chain <= 4'h0;
    end
    else if (tick_rise)
    begin
      cnt <= at_end ? 16'h0 : cnt + 16'h0001;
      chain <= {chain[2:0], store_level};
    end
  end

  // Input buffer and diagnostic pattern source
  wire [DATA_W-1:0] cap_bus = diag_n ? in_buf : diag_pat;
  wire lower_found = cap_bus < low_reg;
  wire higher_found = cap_bus > high_reg;
  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      in_buf <= `CODE_BOTTOM;
      diag_pat <= `CODE_BOTTOM;
    end
    else if (tick_rise)
    begin
      in_buf <= code;
      diag_pat <= diag_pat + 8'h01;
    end
  end

  // Initialization flops feeding selector control input 0
  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      init_a <= 1'b1;
      ctrl0 <= 1'b1;
    end
    else
    begin
      if (!extreme)
        init_a <= 1'b1;
      else if (ctrl0)
        init_a <= 1'b0;
      else if (tick_rise && fp_rise)
        init_a <= 1'b1;
      if (!dual_axis_n)
        ctrl0 <= 1'b0;
      else if (tick_rise)
        ctrl0 <= init_a;
    end
  end

  // Strobe selector: control input 1 is extreme mode
  wire [1:0] sel = {ctrl0, extreme};
  localparam SEL_DUAL = 2'b00;
  localparam SEL_MINMAX = 2'b01;
  localparam SEL_SAMPLE = 2'b10;
  localparam SEL_INIT = 2'b11;
  reg low_strobe;
  reg high_strobe;
  always @*
  begin
    low_strobe = 1'b0;
    high_strobe = 1'b0;
    case (sel)
      SEL_INIT:
      begin
        low_strobe = tick_fall;
        high_strobe = tick_fall;
      end
      SEL_MINMAX:
      begin
        low_strobe = tick_fall && lower_found;
        high_strobe = tick_fall && higher_found;
      end
      SEL_SAMPLE:
      begin
        low_strobe = tick_rise && sp_rise;
        high_strobe = tick_rise && sp_fall;
      end
      SEL_DUAL:
      begin
        low_strobe = tick_rise && fp_rise;
        high_strobe = tick_rise && sp_rise;
      end
      default:
      begin
        low_strobe = 1'b0;
        high_strobe = 1'b0;
      end
    endcase
  end

  // Capture registers and last-extreme latch
  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      low_reg <= `CODE_BOTTOM;
      high_reg <= `CODE_BOTTOM;
      last_min <= 1'b0;
    end
    else
    begin
      if (low_strobe)
        low_reg <= cap_bus;
      if (high_strobe)
        high_reg <= cap_bus;
      if (low_strobe && !high_strobe)
        last_min <= 1'b1;
      else if (high_strobe && !low_strobe)
        last_min <= 1'b0;
    end
  end

  // Write control, handoff and reorder buffers onto the memory buses
  wire handoff = tick_fall && at_end;
  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      capture_write_o <= 1'b0;
      handoff_clock_o <= 1'b0;
      swap_drive_o <= 1'b0;
      plain_drive_o <= 1'b0;
      reo_low <= `CODE_BOTTOM;
      reo_high <= `CODE_BOTTOM;
      mem_bus_a_o <= `CODE_BOTTOM;
      mem_bus_b_o <= `CODE_BOTTOM;
    end
    else
    begin
      capture_write_o <= at_end;
      handoff_clock_o <= handoff;
      if (handoff)
      begin
        reo_low <= low_reg;
        reo_high <= high_reg;
        swap_drive_o <= reorder_enable && last_min;
        plain_drive_o <= !(reorder_enable && last_min);
        mem_bus_a_o <= (reorder_enable && last_min) ? high_reg : low_reg;
        mem_bus_b_o <= (reorder_enable && last_min) ? low_reg : high_reg;
      end
      else if (!at_end)
      begin
        swap_drive_o <= 1'b0;
        plain_drive_o <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

/* testbench/digitizer_model.sv */
// Behavioural digitizer: free-running converter clock and 8-bit codes.
// Assumes the bench sets a start code and a per-conversion step.
`timescale 1ns/1ns
`default_nettype none
module digitizer_model (
  input wire logic [7:0] start_i,
  input wire logic [7:0] step_i,
  input wire logic load_i,
  output logic clk_o,
  output logic [7:0] code_o
);
  // Converter clock at 20 MHz, phase unrelated to the system clock
  initial
  begin
    clk_o = 1'b0;
    code_o = 8'h00;
    #3;
    forever #25 clk_o = ~clk_o;
  end
  // New code each conversion: ff at range top, 00 at range bottom
  always @(negedge clk_o)
    code_o <= load_i ? start_i : code_o + step_i;
endmodule
`default_nettype wire

/* testbench/acq_pipeline_assertions.sv */
// Port checker for the acquisition pipeline.
// Assumes it is bound into the pipeline top module.
`timescale 1ns/1ns
`default_nettype none
module acq_pipeline_checker #(
  parameter DATA_W = 8
)
(
  input wire sys_clk_i,
  input wire rst_b_i,
  input wire [DATA_W-1:0] mem_bus_a_o,
  input wire [DATA_W-1:0] mem_bus_b_o,
  input wire capture_write_o,
  input wire handoff_clock_o,
  input wire swap_drive_o,
  input wire plain_drive_o,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // Handoff is a lone one-cycle pulse
  sequence pulse_s;
    handoff_clock_o ##1 !handoff_clock_o;
  endsequence
  a_handoff_pulse: assert property (handoff_clock_o |-> pulse_s)
    else $error("handoff pulse too long");
  a_handoff_in_write: assert property (handoff_clock_o |-> capture_write_o)
    else $error("handoff outside capture write");
  a_bus_hold: assert property ($changed({mem_bus_a_o, mem_bus_b_o}) |-> handoff_clock_o)
    else $error("memory bus moved without handoff");
  a_drive_excl: assert property (!(swap_drive_o && plain_drive_o))
    else $error("both buffer sets driving");
  a_drive_start: assert property ($rose(swap_drive_o || plain_drive_o)
    |-> handoff_clock_o || $past(handoff_clock_o))
    else $error("buffer drive without handoff");
  a_drive_end: assert property ($fell(capture_write_o)
    |-> ##[0:1] !(swap_drive_o || plain_drive_o))
    else $error("buffer drive outlives capture write");
  a_bresp_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_rdata_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
endmodule
bind acquisition_min_max_pipeline acq_pipeline_checker #(.DATA_W(DATA_W)) chk_i (
  .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .mem_bus_a_o(mem_bus_a_o),
  .mem_bus_b_o(mem_bus_b_o), .capture_write_o(capture_write_o),
  .handoff_clock_o(handoff_clock_o), .swap_drive_o(swap_drive_o),
  .plain_drive_o(plain_drive_o), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the acquisition pipeline.
// Assumes the digitizer model on the pins and an AXI4-Lite master here.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] start = 8'h00, step = 8'h00;
  logic load = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, cw, hand, swp, pln, dclk;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] bus_a, bus_b, dcode;
  int fail_count = 0;
  int n_compared = 0;
  // System clock, 125 MHz
  always #4 clk = ~clk;
  digitizer_model dig (.start_i(start), .step_i(step), .load_i(load), .clk_o(dclk),
    .code_o(dcode));
  acquisition_min_max_pipeline DUT (.sys_clk_i(clk), .rst_b_i(rst_b),
    .digitizer_clock_i(dclk), .digitizer_data_i(dcode), .mem_bus_a_o(bus_a),
    .mem_bus_b_o(bus_b), .capture_write_o(cw), .handoff_clock_o(hand),
    .swap_drive_o(swp), .plain_drive_o(pln), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  task automatic report_and_stop;
    if (fail_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic hung(input int n);
    if (n >= 300)
    begin
      fail_count++;
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (!bvalid && n < 300);
    bready <= 1'b0;
    hung(n);
    chk("bresp", bresp, r);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (arready)
        arvalid <= 1'b0;
    end while (!rvalid && n < 300);
    d = rdata;
    rready <= 1'b0;
    hung(n);
    chk("rresp", rresp, 2'b00);
  endtask
  // Preset the code, then ramp by step per conversion
  task automatic feed(input logic [7:0] s, input logic [7:0] st);
    start <= s;
    step <= st;
    load <= 1'b1;
    repeat (20) @(posedge clk);
    load <= 1'b0;
  endtask
  // Second handoff, then settled memory bus
  task automatic grab;
    int n;
    repeat (2)
    begin
      n = 0;
      do
      begin
        @(posedge clk);
        n++;
      end while (!hand && n < 300);
      hung(n);
    end
    @(posedge clk);
  endtask
  task automatic t_regs;
    logic [31:0] d;
    rd(4'h0, d);
    chk("mode", d, 32'h1a);
    rd(4'h4, d);
    chk("period", d, 32'h4);
    wr(4'h8, 32'h1, 2'b10);
    wr(4'hc, 32'h1, 2'b10);
    wr(4'h4, 32'h1, 2'b00);
    rd(4'h4, d);
    chk("period_min", d, 32'h2);
    wr(4'h4, 32'h8, 2'b00);
  endtask
  task automatic t_codes;
    logic [31:0] d;
    logic [7:0] c [3] = '{8'hff, 8'h00, 8'h5a};
    foreach (c[i])
    begin
      feed(c[i], 8'h00);
      grab();
      chk("bus_a", bus_a, c[i]);
      chk("bus_b", bus_b, c[i]);
      chk("plain", pln, 1'b1);
      chk("capture_write", cw, 1'b1);
      rd(4'h8, d);
      chk("in_buf", d[23:16], c[i]);
    end
  endtask
  task automatic t_diag;
    wr(4'h0, 32'h12, 2'b00);
    grab();
    chk("diag_gap", 8'(bus_b - bus_a), 32'h4);
  endtask
  task automatic t_xy;
    wr(4'h0, 32'h18, 2'b00);
    feed(8'h20, 8'h01);
    grab();
    chk("xy_gap", bus_b - bus_a, 32'h1);
  endtask
  task automatic t_minmax;
    logic [7:0] lo, hi;
    logic [7:0] m [3] = '{8'h1f, 8'h1f, 8'h0b};
    logic [7:0] s [3] = '{8'h01, 8'hff, 8'hff};
    foreach (m[i])
    begin
      wr(4'h0, {24'h0, m[i]}, 2'b00);
      feed(8'h80, s[i]);
      grab();
      chk("swap", swp, i == 1);
      chk("plain", pln, i != 1);
      lo = swp ? bus_b : bus_a;
      hi = swp ? bus_a : bus_b;
      chk("span", hi > lo && hi - lo >= 8'h03, 1'b1);
    end
  endtask
  // Reset, then every scenario in turn
  initial
  begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_codes();
    t_diag();
    t_xy();
    t_minmax();
    report_and_stop();
  end
endmodule
`default_nettype wire
